// ---- inc/ibb_map.svh ----
// Offsets, command codes, status fields and timing for the wire bridge
`ifndef IBB_MAP_SVH
`define IBB_MAP_SVH

// Link address (7 bits) and command codes
`define IBB_DEV_ADDR       7'h18
`define IBB_CMD_SLOT       8'h87
`define IBB_CMD_WBYTE      8'hA5
`define IBB_CMD_RBYTE      8'h96
`define IBB_CMD_SET_PTR    8'hC3

// Read pointer codes
`define IBB_PTR_STATUS     8'hF0
`define IBB_PTR_RDATA      8'hE1

// Status register fields and reset values
`define IBB_ST_BUSY_BIT    0
`define IBB_ST_SLOT_BIT    1
`define IBB_RDATA_RESET    8'h00

// Wire timing, in ns, and the core clock period
`define IBB_CLK_PERIOD_NS  10
`define IBB_T_SLOT_NS      70000
`define IBB_T_LOW1_NS      6000
`define IBB_T_LOW0_NS      60000
`define IBB_T_SAMPLE_NS    15000

// Cycle counts; least times round up
`define IBB_SLOT_CYC  ((`IBB_T_SLOT_NS + `IBB_CLK_PERIOD_NS - 1) / `IBB_CLK_PERIOD_NS)
`define IBB_LOW1_CYC  ((`IBB_T_LOW1_NS + `IBB_CLK_PERIOD_NS - 1) / `IBB_CLK_PERIOD_NS)
`define IBB_LOW0_CYC  ((`IBB_T_LOW0_NS + `IBB_CLK_PERIOD_NS - 1) / `IBB_CLK_PERIOD_NS)
`define IBB_SAMPLE_CYC ((`IBB_T_SAMPLE_NS + `IBB_CLK_PERIOD_NS - 1) / `IBB_CLK_PERIOD_NS)

`endif

// ---- inc/ibb_pkg.sv ----
// Types shared by the wire bridge
package ibb_pkg;

	// Link slave states
	typedef enum logic [2:0] {I_IDLE, I_ADDR, I_WR, I_WACK, I_RD, I_RACK} ibb_link_st_t;

	// Wire engine states
	typedef enum logic [0:0] {W_IDLE, W_BIT} ibb_wire_st_t;

	// One queued wire operation
	typedef struct packed {
		logic [7:0] cmd;
		logic [7:0] data;
	} ibb_op_t;

endpackage

// ---- core/ibb_bridge.sv ----
// Link slave, command queue and wire engine of the wire bridge
`timescale 1ns/100ps
`include "ibb_map.svh"

// =====================================================================
// Queue of pending wire operations
module ibb_fifo #(
	parameter int W = 16,
	parameter int D = 8
) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem_q [D];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [AW:0]   cnt_q, cnt_d;
	logic          push, pop;

	// Honest flags from the fill count
	assign in_ready  = (cnt_q != (AW+1)'(D));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rp_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Pointer and count next values
	always_comb
	begin
		wp_d  = push ? ((wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1) : wp_q;
		rp_d  = pop ? ((rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1) : rp_q;
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	end

	// Storage has no reset; only the pointers and the fill count need one
	always_ff @(posedge core_clk)
	begin
		if (push)
			mem_q[wp_q] <= in_data;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			wp_q  <= wp_d;
			rp_q  <= rp_d;
			cnt_q <= cnt_d;
		end
	end
endmodule

// =====================================================================
// Overview of operation
// [R1] After slot command and parameter finish, status read returns slot result.
// [R2] Once busy falls after a slot, status holds that slot's valid result.
// [R3] While busy, every wire command code is answered with not-acknowledge.
// [R4] Master stops and restarts after a refused command code.
// [R5] Write-byte command plus one data byte in one transfer; byte goes onto wire.
// [R6] Write-byte captures nothing and leaves the read data register untouched.
// [R7] Busy falling after write-byte means the whole byte went out on the wire.
// [R8] Read-byte takes no parameter; result read after pointing at read data.
// [R9] Set-read-pointer to read data is accepted while a read-byte runs.
// [R10] Master polls status until idle, then points at read data and reads.
// [R11] With pointer at status, every read byte returns fresh status.
module ibb_bridge #(
	parameter int SLOT_CYC   = `IBB_SLOT_CYC,
	parameter int LOW1_CYC   = `IBB_LOW1_CYC,
	parameter int LOW0_CYC   = `IBB_LOW0_CYC,
	parameter int SAMPLE_CYC = `IBB_SAMPLE_CYC,
	parameter int Q_DEPTH    = 8
) (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe_n,
	input  wire logic wire_in,
	output logic      wire_out,
	output logic      wire_oe_n
);
	import ibb_pkg::*;

	// =================================================================
	// Synchronisers and link edge detection
	logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3, win_s1, win_s2;
	logic scl_rise, scl_fall, start_det, stop_det;

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			{scl_s1, scl_s2, scl_s3} <= 3'h7;
			{sda_s1, sda_s2, sda_s3} <= 3'h7;
			{win_s1, win_s2}         <= 2'h3;
		end
		else
		begin
			{scl_s1, scl_s2, scl_s3} <= {scl_in, scl_s1, scl_s2};
			{sda_s1, sda_s2, sda_s3} <= {sda_in, sda_s1, sda_s2};
			{win_s1, win_s2}         <= {wire_in, win_s1};
		end
	end

	// Start and stop are data edges while the clock stays high
	assign scl_rise  = scl_s2 && !scl_s3;
	assign scl_fall  = !scl_s2 && scl_s3;
	assign start_det = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
	assign stop_det  = scl_s2 && scl_s3 && !sda_s3 && sda_s2;

	// =================================================================
	// Shared state between link side and wire side
	ibb_link_st_t is_q, is_d;
	ibb_wire_st_t ws_q, ws_d;
	ibb_op_t      q_in, q_out;
	logic         q_push, q_rdy, q_val, q_pop;
	logic [7:0]   rdat_q, rdat_d, ptr_q, ptr_d, status, tx_byte;
	logic         slot_q, slot_d, busy;

	// Pending queue entries count as busy, so a second command cannot slip in
	assign busy    = (ws_q == W_BIT) || q_val;
	assign status  = {6'h00, slot_q, busy} & 8'h03;
	// Pointer selects the byte sent on every read slot
	assign tx_byte = (ptr_q == `IBB_PTR_RDATA) ? rdat_q : status; // [R1] [R11]

	ibb_fifo #(
		.W (16),
		.D (Q_DEPTH)
	) u_queue (
		.core_clk  (core_clk),
		.rst       (rst),
		.in_valid  (q_push),
		.in_ready  (q_rdy),
		.in_data   (q_in),
		.out_valid (q_val),
		.out_ready (q_pop),
		.out_data  (q_out)
	);

	// =================================================================
	// Link slave: address, command bytes, acknowledge and read-out
	logic [3:0] bc_q, bc_d;
	logic [7:0] sh_q, sh_d, cmd_q, cmd_d;
	logic       rw_q, rw_d, drv_q, drv_d, nak_q, nak_d, ph_q, ph_d, ok;

	always_comb
	begin
		is_d = is_q; bc_d = bc_q; sh_d = sh_q; rw_d = rw_q; drv_d = drv_q;
		nak_d = nak_q; ph_d = ph_q; cmd_d = cmd_q; ptr_d = ptr_q;
		q_push = 1'b0; q_in = '0; ok = 1'b0;
		if (start_det)
		begin
			is_d = I_ADDR; bc_d = '0; drv_d = 1'b0; ph_d = 1'b0;
		end
		else if (stop_det)
		begin
			is_d = I_IDLE; drv_d = 1'b0; ph_d = 1'b0;
		end
		else
		begin
			case (is_q)
			I_ADDR, I_WR:
			begin
				if (scl_rise)
				begin
					sh_d = {sh_q[6:0], sda_s2};
					bc_d = bc_q + 4'h1;
				end
				else if (scl_fall && bc_q == 4'h8)
				begin
					if (is_q == I_ADDR)
					begin
						ok   = (sh_q[7:1] == `IBB_DEV_ADDR);
						rw_d = sh_q[0];
					end
					else if (!ph_q)
					begin
						// Command byte; the set-pointer code itself is never refused, even while busy
						case (sh_q)
						`IBB_CMD_SET_PTR:
							ok = 1'b1; // [R9]
						`IBB_CMD_SLOT, `IBB_CMD_WBYTE:
							ok = !busy && q_rdy; // [R3]
						`IBB_CMD_RBYTE:
						begin
							ok     = !busy && q_rdy; // [R3]
							q_push = ok; // [R8]
							q_in   = '{cmd: sh_q, data: 8'h00};
							if (ok)
								ptr_d = `IBB_PTR_STATUS;
						end
						default:
							ok = 1'b0;
						endcase
						ph_d  = ok && (sh_q != `IBB_CMD_RBYTE);
						cmd_d = sh_q;
					end
					else if (cmd_q == `IBB_CMD_SET_PTR)
					begin
						ok   = (sh_q == `IBB_PTR_RDATA) || (sh_q == `IBB_PTR_STATUS);
						ph_d = 1'b0;
						if (ok)
							ptr_d = sh_q; // [R8] [R9] [R10]
					end
					else
					begin
						// Parameter byte completes a slot or write-byte operation
						ok     = q_rdy;
						ph_d   = 1'b0;
						q_push = ok; // [R5]
						q_in   = '{cmd: cmd_q, data: sh_q};
						ptr_d  = `IBB_PTR_STATUS;
					end
					nak_d = !ok;
					drv_d = ok;
					is_d  = I_WACK;
				end
			end
			I_WACK:
			begin
				if (scl_fall)
				begin
					drv_d = 1'b0;
					bc_d  = '0;
					if (nak_q)
						is_d = I_IDLE; // [R3] [R4]
					else if (rw_q)
					begin
						sh_d  = tx_byte;
						drv_d = !tx_byte[7];
						is_d  = I_RD;
					end
					else
						is_d = I_WR;
				end
			end
			I_RD:
			begin
				if (scl_rise)
					bc_d = bc_q + 4'h1;
				else if (scl_fall)
				begin
					if (bc_q == 4'h8)
					begin
						drv_d = 1'b0;
						is_d  = I_RACK;
					end
					else
					begin
						sh_d  = {sh_q[6:0], 1'b0};
						drv_d = !sh_q[6];
					end
				end
			end
			I_RACK:
			begin
				if (scl_rise)
					nak_d = sda_s2;
				else if (scl_fall)
				begin
					if (nak_q)
						is_d = I_IDLE;
					else
					begin
						// Reload keeps status polling live within one transfer
						sh_d  = tx_byte; // [R11]
						drv_d = !tx_byte[7];
						bc_d  = '0;
						is_d  = I_RD;
					end
				end
			end
			default:
				is_d = I_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			is_q <= I_IDLE; bc_q <= '0; sh_q <= '0; rw_q <= 1'b0; drv_q <= 1'b0;
			nak_q <= 1'b0; ph_q <= 1'b0; cmd_q <= '0; ptr_q <= `IBB_PTR_STATUS;
		end
		else
		begin
			is_q <= is_d; bc_q <= bc_d; sh_q <= sh_d; rw_q <= rw_d; drv_q <= drv_d;
			nak_q <= nak_d; ph_q <= ph_d; cmd_q <= cmd_d; ptr_q <= ptr_d;
		end
	end

	// Only zeros are driven; the pull-up makes the ones
	assign sda_out  = 1'b0;
	assign sda_oe_n = !drv_q;

	// =================================================================
	// Wire engine: one time slot per bit, LSB first
	logic [15:0] tm_q, tm_d;
	logic [7:0]  wsh_q, wsh_d, wcmd_q, wcmd_d;
	logic [3:0]  wn_q, wn_d;
	logic        wdrv_q, wdrv_d, smp_q, smp_d;

	always_comb
	begin
		ws_d = ws_q; tm_d = tm_q; wsh_d = wsh_q; wcmd_d = wcmd_q; wn_d = wn_q;
		wdrv_d = wdrv_q; smp_d = smp_q; rdat_d = rdat_q; slot_d = slot_q; q_pop = 1'b0;
		case (ws_q)
		W_IDLE:
		begin
			wdrv_d = 1'b0;
			if (q_val)
			begin
				q_pop  = 1'b1;
				wcmd_d = q_out.cmd;
				tm_d   = '0;
				wdrv_d = 1'b1;
				ws_d   = W_BIT;
				// Slot sends the parameter's top bit; read sends ones to sample
				if (q_out.cmd == `IBB_CMD_SLOT)
				begin
					wsh_d = {7'h00, q_out.data[7]};
					wn_d  = 4'h1;
				end
				else
				begin
					wsh_d = (q_out.cmd == `IBB_CMD_WBYTE) ? q_out.data : 8'hFF; // [R5]
					wn_d  = 4'h8;
				end
			end
		end
		W_BIT:
		begin
			tm_d   = tm_q + 16'h0001;
			wdrv_d = (tm_d < (wsh_q[0] ? 16'(LOW1_CYC) : 16'(LOW0_CYC)));
			if (tm_q == 16'(SAMPLE_CYC))
				smp_d = win_s2;
			if (tm_q == 16'(SLOT_CYC - 1))
			begin
				wsh_d = {smp_q, wsh_q[7:1]};
				wn_d  = wn_q - 4'h1;
				tm_d  = '0;
				if (wn_q == 4'h1)
				begin
					// Results land together with busy falling
					ws_d   = W_IDLE; // [R7]
					wdrv_d = 1'b0;
					if (wcmd_q == `IBB_CMD_RBYTE)
						rdat_d = {smp_q, wsh_q[7:1]}; // [R6] [R8]
					if (wcmd_q == `IBB_CMD_SLOT)
						slot_d = smp_q; // [R1] [R2]
				end
				else
					wdrv_d = 1'b1;
			end
		end
		default:
			ws_d = W_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			ws_q <= W_IDLE; tm_q <= '0; wsh_q <= '0; wcmd_q <= '0; wn_q <= '0;
			wdrv_q <= 1'b0; smp_q <= 1'b0; rdat_q <= `IBB_RDATA_RESET; slot_q <= 1'b0;
		end
		else
		begin
			ws_q <= ws_d; tm_q <= tm_d; wsh_q <= wsh_d; wcmd_q <= wcmd_d; wn_q <= wn_d;
			wdrv_q <= wdrv_d; smp_q <= smp_d; rdat_q <= rdat_d; slot_q <= slot_d;
		end
	end

	assign wire_out  = 1'b0;
	assign wire_oe_n = !wdrv_q;
endmodule

// ---- tb/ibb_bridge_checker.sv ----
// Port checker for the wire bridge
`timescale 1ns/100ps
// ==========
// Checker
module ibb_bridge_checker #(
	parameter int SLOT_CYC = 70,
	parameter int LOW1_CYC = 6,
	parameter int LOW0_CYC = 60
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	input wire logic wire_in,
	input wire logic wire_out,
	input wire logic wire_oe_n
);
	logic [15:0] lo_q;
	logic [15:0] lo_d;
	logic [15:0] gap_q;
	logic [15:0] gap_d;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	// Low length, and cycles since the last slot start
	always_comb
	begin
		lo_d = wire_oe_n ? 16'h0000 : lo_q + 16'h0001;
		gap_d = (gap_q == 16'hFFFF) ? gap_q : gap_q + 16'h0001;
		if (!wire_oe_n && lo_q == 16'h0000)
			gap_d = 16'h0001;
	end
	// Saturated start keeps the first slot after reset legal
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			lo_q <= 16'h0000;
			gap_q <= 16'hFFFF;
		end
		else
		begin
			lo_q <= lo_d;
			gap_q <= gap_d;
		end
	end
	// Pins only ever pull low
	sda_out_zero_a: assert property (sda_out == 1'b0)
		else $error("link data driven high");
	wire_out_zero_a: assert property (wire_out == 1'b0)
		else $error("wire driven high");
	// Link data held through a clock high phase
	sda_hold_a: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*8])
		else $error("link pull too short");
	sda_stable_a: assert property ($changed(sda_oe_n) |->
		!(scl_in && $past(scl_in) && $past(scl_in, 2) && $past(scl_in, 3)))
		else $error("link data moved while clock high");
	// Wire slot shape
	low_len_a: assert property ($rose(wire_oe_n) |->
		lo_q inside {[LOW1_CYC-1:LOW1_CYC+1], [LOW0_CYC-1:LOW0_CYC+1]})
		else $error("wire low length wrong");
	low_max_a: assert property (lo_q <= LOW0_CYC + 1)
		else $error("wire held low too long");
	slot_gap_a: assert property ($fell(wire_oe_n) |-> gap_q >= SLOT_CYC)
		else $error("slots too close");
	rst_idle_a: assert property ($fell(rst) |-> (sda_oe_n && wire_oe_n) [*3])
		else $error("pin driven after reset");
	cover property ($rose(wire_oe_n) && lo_q > LOW1_CYC + 1);
	cover property ($fell(sda_oe_n));
	cover property ($fell(wire_oe_n) && gap_q == SLOT_CYC);
endmodule

bind ibb_bridge ibb_bridge_checker #(
	.SLOT_CYC(SLOT_CYC),
	.LOW1_CYC(LOW1_CYC),
	.LOW0_CYC(LOW0_CYC)
) ibb_bridge_checker_inst (.core_clk, .rst, .scl_in, .sda_in, .sda_out, .sda_oe_n,
	.wire_in, .wire_out, .wire_oe_n);

// ---- tb/ibb_far_model.sv ----
// Link master and wire slave facing the bridge
`timescale 1ns/100ps
// ==========
// Far-side models
module ibb_far_model (
	output logic      scl,
	output logic      m_pull,
	input  wire logic sda,
	input  wire logic wire_ln,
	output logic      s_pull
);
	logic [7:0] pat = 8'hFF;
	logic [7:0] cap;
	int         idx = 0;
	realtime    t0;
	initial
	begin
		scl = 1'b1;
		m_pull = 1'b0;
		s_pull = 1'b0;
	end
	// One link bit, sampled mid-high
	task automatic lbit(input logic b, output logic r);
		m_pull = !b;
		#31.25 scl = 1'b1;
		#31.25 r = sda;
		#31.25 scl = 1'b0;
		#31.25;
	endtask
	// Start (0) or stop (1); a refused code is ended by stop
	task automatic cond(input logic stp);
		m_pull = stp;
		#31.25 scl = 1'b1;
		#31.25 m_pull = !stp;
		#31.25 scl = stp;
		#31.25;
	endtask
	// Byte MSB first; l is the ack slot level sent
	task automatic xfer(input logic [7:0] d, input logic l, output logic [7:0] q,
		output logic a);
		logic r;
		for (int i = 7; i >= 0; i--)
			lbit(d[i], q[i]);
		lbit(l, r);
		a = !r;
	endtask
	// Zero bits held low past the sample point
	always @(negedge wire_ln)
	begin
		t0 = $realtime;
		s_pull = !pat[idx];
		idx = (idx + 1) % 8;
		#300 s_pull = 1'b0;
	end
	// Short low reads as one, LSB first
	always @(posedge wire_ln)
		cap = {($realtime - t0) < 300.0, cap[7:1]};
endmodule

// ---- tb/ibb_bridge_tb.sv ----
// Self-checking bench for the wire bridge
`timescale 1ns/100ps
`include "ibb_map.svh"
// ==========
// Bench top
module ibb_bridge_tb;
	typedef struct {logic [7:0] cmd, par, pat, st, rd;} ibb_row_t;
	localparam logic [7:0] AW = {`IBB_DEV_ADDR, 1'b0};
	localparam logic [7:0] AR = {`IBB_DEV_ADDR, 1'b1};
	logic       core_clk, rst, scl, m_pull, s_pull, sda_oe_n, wire_oe_n, sda, wln, a;
	logic [7:0] q;
	int         failures, n_compared;
	ibb_row_t   rows [5];
	// Pull-ups on both lines
	assign sda = sda_oe_n & !m_pull;
	assign wln = wire_oe_n & !s_pull;
	ibb_bridge #(.SLOT_CYC(70), .LOW1_CYC(6), .LOW0_CYC(60), .SAMPLE_CYC(15))
	ibb_bridge_inst (.core_clk, .rst, .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe_n,
		.wire_in(wln), .wire_out(), .wire_oe_n);
	ibb_far_model ibb_far_model_inst (.scl, .m_pull, .sda, .wire_ln(wln), .s_pull);
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic xb(input logic [7:0] d, input logic l);
		ibb_far_model_inst.xfer(d, l, q, a);
	endtask
	task automatic cn(input logic s);
		ibb_far_model_inst.cond(s);
	endtask
	// Point the reader, then fetch one byte
	task automatic rd(input logic [7:0] ptr);
		cn(0);
		xb(AW, 1);
		xb(`IBB_CMD_SET_PTR, 1);
		xb(ptr, 1);
		cn(0);
		xb(AR, 1);
		xb(8'hFF, 1);
		cn(1);
	endtask
	// Read status bytes in one transfer until idle
	task automatic poll;
		int n;
		cn(0);
		xb(AR, 1);
		chk(a, 1'b1);
		xb(8'hFF, 0);
		for (n = 0; n < 40 && q[`IBB_ST_BUSY_BIT]; n++)
			xb(8'hFF, 0);
		if (n == 40)
		begin
			failures++;
			report_and_stop;
		end
		xb(8'hFF, 1);
		cn(1);
	endtask
	initial
	begin
		rst = 1'b1;
		failures = 0;
		n_compared = 0;
		rows = '{'{`IBB_CMD_RBYTE, 8'h00, 8'hA5, 8'h00, 8'hA5},
			'{`IBB_CMD_WBYTE, 8'h33, 8'hFF, 8'h00, 8'hA5},
			'{`IBB_CMD_SLOT, 8'h80, 8'hFF, 8'h02, 8'hA5},
			'{`IBB_CMD_SLOT, 8'h80, 8'hFE, 8'h00, 8'hA5},
			'{`IBB_CMD_SLOT, 8'h00, 8'hFF, 8'h00, 8'hA5}};
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		repeat (5) @(posedge core_clk);
		foreach (rows[i])
		begin
			ibb_far_model_inst.pat = rows[i].pat;
			ibb_far_model_inst.idx = 0;
			cn(0);
			xb(AW, 1);
			xb(rows[i].cmd, 1);
			chk(a, 1'b1);
			if (rows[i].cmd != `IBB_CMD_RBYTE)
				xb(rows[i].par, 1);
			poll;
			chk(q, rows[i].st);
			rd(`IBB_PTR_RDATA);
			chk(q, rows[i].rd);
			if (rows[i].cmd == `IBB_CMD_WBYTE)
				chk(ibb_far_model_inst.cap, rows[i].par);
		end
		// Pointer moved to read data while a read byte still runs
		ibb_far_model_inst.pat = 8'h3C;
		ibb_far_model_inst.idx = 0;
		cn(0);
		xb(AW, 1);
		xb(`IBB_CMD_RBYTE, 1);
		cn(0);
		xb(AW, 1);
		xb(`IBB_CMD_SET_PTR, 1);
		xb(`IBB_PTR_RDATA, 1);
		chk(a, 1'b1);
		cn(1);
		repeat (700) @(posedge core_clk);
		cn(0);
		xb(AR, 1);
		xb(8'hFF, 1);
		chk(q, 8'h3C);
		cn(1);
		// Command refused while a write byte runs; the refusal comes well inside its slots
		ibb_far_model_inst.pat = 8'hFF;
		cn(0);
		xb(AW, 1);
		xb(`IBB_CMD_WBYTE, 1);
		xb(8'h33, 1);
		cn(1);
		cn(0);
		xb(AW, 1);
		xb(`IBB_CMD_SLOT, 1);
		chk(a, 1'b0);
		cn(1);
		poll;
		chk(ibb_far_model_inst.cap, 8'h33);
		// Retry after stop is taken once idle
		cn(0);
		xb(AW, 1);
		xb(`IBB_CMD_SLOT, 1);
		chk(a, 1'b1);
		xb(8'h80, 1);
		cn(1);
		poll;
		chk(q, 8'h02);
		// Foreign address is refused
		cn(0);
		xb(AW ^ 8'h02, 1);
		chk(a, 1'b0);
		cn(1);
		// Reset in mid-run
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		repeat (5) @(posedge core_clk);
		rd(`IBB_PTR_STATUS);
		chk(q, 8'h00);
		rd(`IBB_PTR_RDATA);
		chk(q, `IBB_RDATA_RESET);
		report_and_stop;
	end
endmodule
